// ===== core/ipr_apb_if.sv
// APB slave front end: phase decode, address decode and response
`timescale 1ns/1ps
`default_nettype none
module ipr_apb_if (
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic ce,
  output logic setup,
  output logic wr_fire,
  output logic hit,
  output logic [2:0] idx,
  output logic pready,
  output logic pslverr
);

  logic [3:0] dec;

  always_comb begin
    dec = ipr_pkg::ipr_decode(paddr);
    hit = dec[3];
    idx = dec[2:0];
    // A frozen block holds the access phase open
    setup = psel & ~penable & ce;
    pready = psel & penable & ce;
    pslverr = pready & ~hit;
    wr_fire = pready & pwrite & hit;
  end

endmodule
`default_nettype wire

// ===== core/ipr_lvl_dec.sv
// Decode of one priority field into level and source enable
`timescale 1ns/1ps
`default_nettype none
module ipr_lvl_dec (
  input wire logic [2:0] field,
  output logic [2:0] level,
  output logic enabled
);

  always_comb begin
    level = field;
    enabled = (field != ipr_pkg::IPR_LVL_OFF);
  end

endmodule
`default_nettype wire

// ===== core/ipr_regs.sv
// Interrupt priority control registers 14 to 19 behind an APB slave
//
// Notes on behaviour
// - Each field is three bits; 111 means level 7, highest.
// - Field code 001 means level 1, the lowest active level.
// - Field code 000 disables the source entirely.
// - All field bits read/write; reset loads 100, level 4.
// - Unassigned bits, bit 15 and gaps between fields, read zero.
// - Reg 14: serial2 rx, serial1 rx, serial4 rx, keystore done.
// - Reg 15: capcmp1, rtc, dma5, serial3 rx.
// - Reg 16: crc error, uart2 error, uart1 error, capcmp2.
// - Reg 17: i2c3 master 14-12, slave 10-8; bits 7-0 zero.
// - Reg 18: capcmp7 at 6-4, voltage detect at 2-0; rest zero.
// - Reg 19: dac at 10-8, charge time at 6-4; rest zero.
`timescale 1ns/1ps
`default_nettype none
module ipr_regs (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [17:0] SRC_ENABLED,
  output logic [2:0] SERIAL2_RX_LEVEL,
  output logic [2:0] SERIAL1_RX_LEVEL,
  output logic [2:0] SERIAL4_RX_LEVEL,
  output logic [2:0] KEYSTORE_DONE_LEVEL,
  output logic [2:0] CAPCMP1_LEVEL,
  output logic [2:0] RTC_LEVEL,
  output logic [2:0] DMA5_LEVEL,
  output logic [2:0] SERIAL3_RX_LEVEL,
  output logic [2:0] CRC_ERROR_LEVEL,
  output logic [2:0] UART2_ERROR_LEVEL,
  output logic [2:0] UART1_ERROR_LEVEL,
  output logic [2:0] CAPCMP2_LEVEL,
  output logic [2:0] I2C3_MASTER_LEVEL,
  output logic [2:0] I2C3_SLAVE_LEVEL,
  output logic [2:0] CAPCMP7_LEVEL,
  output logic [2:0] VOLTAGE_DETECT_LEVEL,
  output logic [2:0] DAC_LEVEL,
  output logic [2:0] CHARGE_TIME_LEVEL
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0][15:0] ctrl;
    logic [31:0] rdata;
    logic [17:0] en;
  } ipr_state_s;

  // Reset value per register is the level-4 pattern under its mask
  localparam ipr_state_s IPR_RST = '{
    ctrl: {ipr_pkg::IPR_RST_PATTERN & ipr_pkg::IPR_MASK[5],
           ipr_pkg::IPR_RST_PATTERN & ipr_pkg::IPR_MASK[4],
           ipr_pkg::IPR_RST_PATTERN & ipr_pkg::IPR_MASK[3],
           ipr_pkg::IPR_RST_PATTERN & ipr_pkg::IPR_MASK[2],
           ipr_pkg::IPR_RST_PATTERN & ipr_pkg::IPR_MASK[1],
           ipr_pkg::IPR_RST_PATTERN & ipr_pkg::IPR_MASK[0]},
    rdata: 32'h0,
    en: {ipr_pkg::IPR_NSRC{1'b1}}
  };

  ipr_state_s st_reg;
  ipr_state_s st_next;

  logic setup;
  logic wr_fire;
  logic hit;
  logic [2:0] idx;
  logic [17:0] en_next;
  logic [5:0][15:0] ctrl_nx;

  // Field of source s within a register image
  function automatic logic [2:0] src_field(input logic [5:0][15:0] img,
      input int s);
    return img[ipr_pkg::IPR_SRC_REG[s]]
      [ipr_pkg::IPR_SRC_LSB[s] +: ipr_pkg::IPR_FW];
  endfunction

  // Register image after this cycle's write; built from st_reg alone so
  // the enable decode never feeds back into the state copy
  function automatic logic [5:0][15:0] ipr_apply(
      input logic [5:0][15:0] cur, input logic fire, input logic [2:0] sel,
      input logic [15:0] wdata, input logic [1:0] strb);
    logic [5:0][15:0] img;
    img = cur;
    for (int k = 0; k < ipr_pkg::IPR_NREG; k++) begin
      if (fire && sel == 3'(k)) begin
        img[k] = ipr_pkg::ipr_merge(cur[k], wdata, strb,
          ipr_pkg::IPR_MASK[k]);
      end
    end
    return img;
  endfunction

  assign ctrl_nx = ipr_apply(st_reg.ctrl, wr_fire, idx, PWDATA[15:0],
    PSTRB[1:0]);

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  ipr_apb_if u_apb (
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .ce(CE),
    .setup(setup),
    .wr_fire(wr_fire),
    .hit(hit),
    .idx(idx),
    .pready(PREADY),
    .pslverr(PSLVERR)
  );

  // ----------------------------------------------------------------
  // Field decode on the next register image, so the enable flags
  // update on the same edge as the fields
  // ----------------------------------------------------------------
  for (genvar s = 0; s < ipr_pkg::IPR_NSRC; s++) begin : g_src
    logic [2:0] fld;
    assign fld = src_field(ctrl_nx, s);
    ipr_lvl_dec u_dec (
      .field(fld),
      .level(),
      .enabled(en_next[s])
    );
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.ctrl = ctrl_nx;
    // Read data is latched in the setup phase and held through access
    if (setup) begin
      if (hit && !PWRITE) begin
        st_next.rdata = {16'h0, st_reg.ctrl[idx]};
      end else begin
        st_next.rdata = 32'h0;
      end
    end
    st_next.en = en_next;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_reg <= IPR_RST;
    end else if (CE) begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign PRDATA = st_reg.rdata;
  assign SRC_ENABLED = st_reg.en;
  assign SERIAL2_RX_LEVEL = src_field(st_reg.ctrl, 0);
  assign SERIAL1_RX_LEVEL = src_field(st_reg.ctrl, 1);
  assign SERIAL4_RX_LEVEL = src_field(st_reg.ctrl, 2);
  assign KEYSTORE_DONE_LEVEL = src_field(st_reg.ctrl, 3);
  assign CAPCMP1_LEVEL = src_field(st_reg.ctrl, 4);
  assign RTC_LEVEL = src_field(st_reg.ctrl, 5);
  assign DMA5_LEVEL = src_field(st_reg.ctrl, 6);
  assign SERIAL3_RX_LEVEL = src_field(st_reg.ctrl, 7);
  assign CRC_ERROR_LEVEL = src_field(st_reg.ctrl, 8);
  assign UART2_ERROR_LEVEL = src_field(st_reg.ctrl, 9);
  assign UART1_ERROR_LEVEL = src_field(st_reg.ctrl, 10);
  assign CAPCMP2_LEVEL = src_field(st_reg.ctrl, 11);
  assign I2C3_MASTER_LEVEL = src_field(st_reg.ctrl, 12);
  assign I2C3_SLAVE_LEVEL = src_field(st_reg.ctrl, 13);
  assign CAPCMP7_LEVEL = src_field(st_reg.ctrl, 14);
  assign VOLTAGE_DETECT_LEVEL = src_field(st_reg.ctrl, 15);
  assign DAC_LEVEL = src_field(st_reg.ctrl, 16);
  assign CHARGE_TIME_LEVEL = src_field(st_reg.ctrl, 17);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  logic full_wr;
  assign full_wr = wr_fire && PSTRB[1:0] == 2'h3;

  level_max_a: assert property (
    (full_wr && idx == ipr_pkg::IPR_IDX15 && PWDATA[14:12] == 3'h7)
    |=> CAPCMP1_LEVEL == ipr_pkg::IPR_LVL_MAX && SRC_ENABLED[4])
    else $error("level 7 write not applied");

  level_min_a: assert property (
    (full_wr && idx == ipr_pkg::IPR_IDX16 && PWDATA[2:0] == 3'h1)
    |=> CAPCMP2_LEVEL == ipr_pkg::IPR_LVL_MIN && SRC_ENABLED[11])
    else $error("level 1 write not applied");

  src_disable_a: assert property (
    (full_wr && idx == ipr_pkg::IPR_IDX14 && PWDATA[2:0] == 3'h0)
    |=> !SRC_ENABLED[3] ##0 KEYSTORE_DONE_LEVEL == 3'h0)
    else $error("zero field left source enabled");

  reset_level_a: assert property (
    !$past(RST_N) |-> DAC_LEVEL == ipr_pkg::IPR_LVL_RST &&
      RTC_LEVEL == ipr_pkg::IPR_LVL_RST && SRC_ENABLED == 18'h3FFFF)
    else $error("reset level is not 4");

  read_back_a: assert property (
    PREADY && !PWRITE && idx == ipr_pkg::IPR_IDX17
    |-> PRDATA == {16'h0, 1'b0, I2C3_MASTER_LEVEL, 1'b0,
      I2C3_SLAVE_LEVEL, 8'h00})
    else $error("read data does not match register 17");

  write_map_a: assert property (
    full_wr && idx == ipr_pkg::IPR_IDX14
    |=> SERIAL2_RX_LEVEL == $past(PWDATA[14:12]) &&
      SERIAL1_RX_LEVEL == $past(PWDATA[10:8]) &&
      SERIAL4_RX_LEVEL == $past(PWDATA[6:4]))
    else $error("register 14 field placement wrong");

  byte_lane_a: assert property (
    (wr_fire && idx == ipr_pkg::IPR_IDX16 && PSTRB[1:0] == 2'h1)
    |=> $stable(CRC_ERROR_LEVEL) && $stable(UART2_ERROR_LEVEL))
    else $error("upper lane written without strobe");

  gap_zero_a: assert property (
    PREADY && !PWRITE && idx == ipr_pkg::IPR_IDX18
    |-> PRDATA == {25'h0, CAPCMP7_LEVEL, 1'b0, VOLTAGE_DETECT_LEVEL})
    else $error("unimplemented bits of register 18 not zero");

  unmapped_a: assert property (
    PREADY
    |-> PSLVERR == ({PADDR[7:2], 2'b00} > ipr_pkg::IPR_OFF_CTRL19) &&
      (!PSLVERR || PWRITE || PRDATA == 32'h0))
    else $error("unmapped access not flagged");

  rtc_map_a: assert property (
    full_wr && idx == ipr_pkg::IPR_IDX15
    |=> RTC_LEVEL == $past(PWDATA[10:8]) &&
      DMA5_LEVEL == $past(PWDATA[6:4]) &&
      SERIAL3_RX_LEVEL == $past(PWDATA[2:0]))
    else $error("register 15 field placement wrong");

  uart_map_a: assert property (
    full_wr && idx == ipr_pkg::IPR_IDX16
    |=> CRC_ERROR_LEVEL == $past(PWDATA[14:12]) &&
      UART2_ERROR_LEVEL == $past(PWDATA[10:8]) &&
      UART1_ERROR_LEVEL == $past(PWDATA[6:4]) &&
      CAPCMP2_LEVEL == $past(PWDATA[2:0]))
    else $error("register 16 field placement wrong");

  i2c3_map_a: assert property (
    full_wr && idx == ipr_pkg::IPR_IDX17
    |=> I2C3_MASTER_LEVEL == $past(PWDATA[14:12]) &&
      I2C3_SLAVE_LEVEL == $past(PWDATA[10:8]))
    else $error("register 17 field placement wrong");

  detect_map_a: assert property (
    full_wr && idx == ipr_pkg::IPR_IDX18
    |=> CAPCMP7_LEVEL == $past(PWDATA[6:4]) &&
      VOLTAGE_DETECT_LEVEL == $past(PWDATA[2:0]))
    else $error("register 18 field placement wrong");

  dac_map_a: assert property (
    full_wr && idx == ipr_pkg::IPR_IDX19
    |=> DAC_LEVEL == $past(PWDATA[10:8]) &&
      CHARGE_TIME_LEVEL == $past(PWDATA[6:4]))
    else $error("register 19 field placement wrong");

  dac_read_a: assert property (
    PREADY && !PWRITE && idx == ipr_pkg::IPR_IDX19
    |-> PRDATA == {21'h0, DAC_LEVEL, 1'b0, CHARGE_TIME_LEVEL, 4'h0})
    else $error("read data does not match register 19");

  low_lane_a: assert property (
    (wr_fire && idx == ipr_pkg::IPR_IDX14 && PSTRB[1:0] == 2'h2)
    |=> $stable(SERIAL4_RX_LEVEL) && $stable(KEYSTORE_DONE_LEVEL) &&
      SERIAL2_RX_LEVEL == $past(PWDATA[14:12]))
    else $error("lower lane written without strobe");

  // A frozen block must not move any enable flag, the read data or the RTC field
  ce_freeze_a: assert property (
    !CE |=> $stable(SRC_ENABLED) && $stable(PRDATA) && $stable(RTC_LEVEL))
    else $error("state changed while clock enable low");

  enable_match_a: assert property (
    SRC_ENABLED[17] == (CHARGE_TIME_LEVEL != ipr_pkg::IPR_LVL_OFF) &&
    SRC_ENABLED[14] == (CAPCMP7_LEVEL != ipr_pkg::IPR_LVL_OFF) &&
    SRC_ENABLED[0] == (SERIAL2_RX_LEVEL != ipr_pkg::IPR_LVL_OFF))
    else $error("enable flags out of step with fields");

  upper_zero_a: assert property (
    PRDATA[31:15] == 17'h0)
    else $error("unassigned read data bits not zero");

endmodule
`default_nettype wire

// ===== include/ipr_pkg.sv
// Package: register map, field layout and helpers of the priority registers
package ipr_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int IPR_NREG = 6;
  localparam int IPR_NSRC = 18;
  localparam int IPR_FW = 3;
  localparam int IPR_AW = 8;
  localparam int IPR_RW = 16;
  localparam int IPR_DW = 32;

  // ----------------------------------------------------------------
  // Register byte addresses on the bus
  // ----------------------------------------------------------------
  localparam logic [7:0] IPR_OFF_CTRL14 = 8'h00;
  localparam logic [7:0] IPR_OFF_CTRL15 = 8'h04;
  localparam logic [7:0] IPR_OFF_CTRL16 = 8'h08;
  localparam logic [7:0] IPR_OFF_CTRL17 = 8'h0C;
  localparam logic [7:0] IPR_OFF_CTRL18 = 8'h10;
  localparam logic [7:0] IPR_OFF_CTRL19 = 8'h14;

  localparam logic [2:0] IPR_IDX14 = 3'h0;
  localparam logic [2:0] IPR_IDX15 = 3'h1;
  localparam logic [2:0] IPR_IDX16 = 3'h2;
  localparam logic [2:0] IPR_IDX17 = 3'h3;
  localparam logic [2:0] IPR_IDX18 = 3'h4;
  localparam logic [2:0] IPR_IDX19 = 3'h5;

  // ----------------------------------------------------------------
  // Implemented bits and reset pattern
  // ----------------------------------------------------------------
  localparam logic [15:0] IPR_MASK [IPR_NREG] = '{
    16'h7777, 16'h7777, 16'h7777, 16'h7700, 16'h0077, 16'h0770};
  localparam logic [15:0] IPR_RST_PATTERN = 16'h4444;
  localparam logic [2:0] IPR_LVL_OFF = 3'h0;
  localparam logic [2:0] IPR_LVL_MIN = 3'h1;
  localparam logic [2:0] IPR_LVL_MAX = 3'h7;
  localparam logic [2:0] IPR_LVL_RST = 3'h4;

  // ----------------------------------------------------------------
  // Source table: owning register and field lsb, in output order
  // ----------------------------------------------------------------
  localparam int IPR_SRC_REG [IPR_NSRC] = '{
    0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2, 3, 3, 4, 4, 5, 5};
  localparam int IPR_SRC_LSB [IPR_NSRC] = '{
    12, 8, 4, 0, 12, 8, 4, 0, 12, 8, 4, 0, 12, 8, 4, 0, 8, 4};

  // Word decode: hit flag and register index
  function automatic logic [3:0] ipr_decode(input logic [7:0] addr);
    logic [3:0] r;
    r = 4'h0;
    case ({addr[7:2], 2'b00})
      IPR_OFF_CTRL14: r = {1'b1, IPR_IDX14};
      IPR_OFF_CTRL15: r = {1'b1, IPR_IDX15};
      IPR_OFF_CTRL16: r = {1'b1, IPR_IDX16};
      IPR_OFF_CTRL17: r = {1'b1, IPR_IDX17};
      IPR_OFF_CTRL18: r = {1'b1, IPR_IDX18};
      IPR_OFF_CTRL19: r = {1'b1, IPR_IDX19};
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  // Byte-lane merge of a write; unimplemented bits forced to zero
  function automatic logic [15:0] ipr_merge(input logic [15:0] old,
      input logic [15:0] wdata, input logic [1:0] strb,
      input logic [15:0] mask);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      r[15:8] = wdata[15:8];
    end
    return r & mask;
  endfunction

endpackage

// ===== tb/ipr_regs_bench.sv
// Self-checking bench of the priority control registers 14 to 19
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
  $display("unexpected %s exp %h got %h", nm, ex, got); \
  fail_count++; end end
module ipr_regs_bench;
  logic CLK, RST_N, CE, PSEL, PENABLE, PWRITE;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [3:0] PSTRB;
  logic PREADY, PSLVERR;
  logic [17:0] SRC_ENABLED;
  logic [2:0] lv [18];
  logic [15:0] mdl [6];
  logic [15:0] msk [6] = '{16'h7777, 16'h7777, 16'h7777, 16'h7700,
    16'h0077, 16'h0770};
  int fail_count = 0;
  int checks_done = 0;
  logic [2:0] c;

  ipr_regs uut (.CLK(CLK), .RST_N(RST_N), .CE(CE), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SRC_ENABLED(SRC_ENABLED), .SERIAL2_RX_LEVEL(lv[0]),
    .SERIAL1_RX_LEVEL(lv[1]), .SERIAL4_RX_LEVEL(lv[2]),
    .KEYSTORE_DONE_LEVEL(lv[3]), .CAPCMP1_LEVEL(lv[4]), .RTC_LEVEL(lv[5]),
    .DMA5_LEVEL(lv[6]), .SERIAL3_RX_LEVEL(lv[7]), .CRC_ERROR_LEVEL(lv[8]),
    .UART2_ERROR_LEVEL(lv[9]), .UART1_ERROR_LEVEL(lv[10]),
    .CAPCMP2_LEVEL(lv[11]), .I2C3_MASTER_LEVEL(lv[12]),
    .I2C3_SLAVE_LEVEL(lv[13]), .CAPCMP7_LEVEL(lv[14]),
    .VOLTAGE_DETECT_LEVEL(lv[15]), .DAC_LEVEL(lv[16]),
    .CHARGE_TIME_LEVEL(lv[17]));

  // ----------------------------------------------------------------
  // Clock, closing and watchdog
  // ----------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Whole run is under a thousand cycles; this leaves a wide margin
  initial begin
    repeat (40000) @(posedge CLK);
    fail_count++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Bus master and model
  // ----------------------------------------------------------------
  // CE is held high at the setup edge, since read data is latched there;
  // it is random while waiting so the access phase gets stretched
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s, output logic [31:0] rd,
      output logic err);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    PSTRB <= s;
    CE <= 1'b1;
    @(posedge CLK);
    PENABLE <= 1'b1;
    CE <= ($urandom_range(3) != 0);
    @(posedge CLK);
    while (PREADY !== 1'b1 && n < 50) begin
      CE <= 1'($urandom_range(1));
      n++;
      @(posedge CLK);
    end
    `CHK("ready", 1'b1, PREADY)
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic check_lv();
    int r, l;
    logic [2:0] f;
    @(negedge CLK);
    for (int k = 0; k < 18; k++) begin
      r = (k < 12) ? k / 4 : (k < 14) ? 3 : (k < 16) ? 4 : 5;
      l = (k < 12) ? 12 - 4 * (k % 4) : (k < 14) ? 12 - 4 * (k - 12)
        : (k < 16) ? 4 - 4 * (k - 14) : 8 - 4 * (k - 16);
      f = mdl[r][l +: 3];
      `CHK("level", f, lv[k])
      `CHK("enable", (f != 3'h0), SRC_ENABLED[k])
    end
  endtask

  task automatic op(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s);
    logic [31:0] rd;
    logic err;
    logic [15:0] v;
    int i;
    i = a[7:2];
    apb(w, a, d, s, rd, err);
    `CHK("error flag", (i > 5), err)
    if (i > 5) begin
      if (!w) `CHK("read data", 32'h0, rd)
    end else if (w) begin
      v = mdl[i];
      if (s[0]) v[7:0] = d[7:0];
      if (s[1]) v[15:8] = d[15:8];
      mdl[i] = v & msk[i];
    end else begin
      `CHK("read data", {16'h0, mdl[i]}, rd)
    end
    check_lv();
  endtask

  task automatic reset_and_read(input int n);
    RST_N <= 1'b0;
    repeat (n) @(posedge CLK);
    RST_N <= 1'b1;
    for (int i = 0; i < 6; i++) mdl[i] = 16'h4444 & msk[i];
    for (int i = 0; i < 6; i++) op(1'b0, 8'(i * 4), 32'h0, 4'h0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    RST_N = 1'b0;
    CE = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    PSTRB = 4'h0;
    void'($urandom(32'h9B98EA60));
    reset_and_read(12);
    // Every code in every field, with all gap bits written as ones
    for (int v = 0; v < 8; v++) begin
      c = 3'(v);
      for (int i = 0; i < 6; i++) begin
        op(1'b1, 8'(i * 4), {16'hFFFF, 1'b1, c, 1'b1, c, 1'b1, c, 1'b1, c},
          4'hF);
        op(1'b0, 8'(i * 4), 32'h0, 4'h0);
      end
    end
    // Random mix of mapped and unmapped words, strobes and data
    repeat (80) begin
      op(1'($urandom_range(1)), 8'($urandom_range(31)), $urandom,
        4'($urandom_range(15)));
    end
    // Mid-run reset, raised just after a rising edge like every input
    @(posedge CLK);
    reset_and_read(2);
    final_report();
  end
endmodule
`default_nettype wire
